/* rtl/resq_pkg.sv */
package resq_pkg;
   // ***************************************************
   // Register map
   // ***************************************************
   localparam logic [7:0] LINREG_B_CONTROL_ADDR = 8'h09;
   localparam logic [7:0] LINREG_A_VOLTAGE_ADDR = 8'h0a;
   localparam logic [7:0] LINREG_B_VOLTAGE_ADDR = 8'h0b;
   localparam logic [7:0] STEPDOWN_A_SEQUENCE_DELAY_ADDR = 8'h0c;
   localparam logic [7:0] STEPDOWN_B_SEQUENCE_DELAY_ADDR = 8'h0d;
   localparam logic [7:0] LINREG_A_SEQUENCE_DELAY_ADDR = 8'h0e;

   // ***************************************************
   // Field layout
   // ***************************************************
   localparam int SW_ON_BIT = 0;
   localparam int PIN_GATING_BIT = 1;
   localparam int DISCHARGE_BIT = 2;
   localparam int CODE_W = 5;
   localparam int WAIT_W = 4;
   localparam int ON_WAIT_LSB = 0;
   localparam int OFF_WAIT_LSB = 4;

   // ***************************************************
   // Reset values and voltage code limit
   // ***************************************************
   localparam logic [2:0] LINREG_B_CONTROL_RST = 3'h4;
   localparam logic [4:0] VOLTAGE_CODE_RST = 5'h00;
   localparam logic [7:0] SEQUENCE_DELAY_RST = 8'h00;
   localparam logic [4:0] VOLTAGE_CODE_MAX = 5'h19;

   // ***************************************************
   // Timing
   // ***************************************************
   localparam int CLOCK_HZ = 50_000_000;
   localparam int STEP_US = 500;
   localparam int STEP_CYCLES = CLOCK_HZ / 1_000_000 * STEP_US;
endpackage

/* rtl/resq_delay_channel.sv */
// ***************************************************
// One delayed output following the enable pin
// ***************************************************
module resq_delay_channel #(
   parameter int TICK_W = 16
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic pin_rise,
   input wire logic pin_fall,
   input wire logic tick,
   input wire logic [3:0] on_wait,
   input wire logic [3:0] off_wait,
   input wire logic on_double,
   input wire logic off_double,
   output logic active
);
   typedef struct packed {
      logic active;
      logic pending;
      logic target;
      logic [4:0] left;
   } resq_ch_t;

   resq_ch_t st;
   resq_ch_t next_st;

   // Steps left: code, doubled when step-select set
   function automatic logic [4:0] steps(input logic [3:0] c,
                                        input logic dbl);
      steps = dbl ? {c, 1'b0} : {1'b0, c};
   endfunction

   // Each pin edge restarts the wait
   always_comb
   begin
      next_st = st;
      if (pin_rise || pin_fall)
      begin
         next_st.target = pin_rise; // RULE13
         next_st.left = pin_rise ? steps(on_wait, on_double)
                                 : steps(off_wait, off_double); // RULE12
         next_st.pending = 1'b1;
         if (next_st.left == 5'h00)
         begin
            next_st.active = pin_rise; // RULE6 RULE8
            next_st.pending = 1'b0;
         end
      end
      else if (st.pending && tick)
      begin
         next_st.left = st.left - 5'h01; // RULE13
         if (st.left == 5'h01)
         begin
            next_st.active = st.target; // RULE7 RULE9 RULE10 RULE11
            next_st.pending = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         st <= '0;
      else if (clk_en)
         st <= next_st;
   end

   assign active = st.active;
endmodule

/* rtl/resq_sequencer.sv */
// ***************************************************
// Regulator enable and sequence delay control
// ***************************************************
// Contract
// RULE1: Discharge of regulator B only while it is off and discharge bit is set.
// RULE2: Pin gating 0: software bit alone; 1: software bit and pin.
// RULE3: Software on bit 0 turns regulator B off or on.
// RULE4: Regulator A voltage code 5 bits, 0x00 to 0x19 valid.
// RULE5: Regulator B voltage code 5 bits in 4:0, 0x00 to 0x19.
// RULE6: Converter A off after code in bits 7:4 from pin fall.
// RULE7: Converter A on after code in bits 3:0 from pin rise.
// RULE8: Converter B off after its shutdown code from pin fall.
// RULE9: Converter B on after its start-up code from pin rise.
// RULE10: Regulator A off after its shutdown code from pin fall.
// RULE11: Regulator A on after its start-up code from pin rise.
// RULE12: Delay equals code times 0.5 ms, or 1 ms with step select.
// RULE13: Delays timed by an internal tick, restarted on each pin edge.
module resq_sequencer #(
   parameter int STEP_CYCLES = resq_pkg::STEP_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic enable_pin,
   input wire logic on_step_double,
   input wire logic off_step_double,
   input wire logic reg_write,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_addr_error,
   output logic linreg_b_on,
   output logic linreg_b_discharge,
   output logic [4:0] linreg_a_voltage_code,
   output logic [4:0] linreg_b_voltage_code,
   output logic linreg_a_code_reserved,
   output logic linreg_b_code_reserved,
   output logic stepdown_a_on,
   output logic stepdown_b_on,
   output logic linreg_a_on
);
   localparam int TICK_W = $clog2(STEP_CYCLES + 1);

   // Refuse a zero step: the tick compare could never match
   if (STEP_CYCLES < 1)
   begin
      $error("STEP_CYCLES must be at least one");
   end

   typedef struct packed {
      logic [2:0] pin_sync;
      logic pin_level;
      logic linreg_b_discharge_on;
      logic linreg_b_pin_gating;
      logic linreg_b_sw_on;
      logic [4:0] linreg_a_voltage_code;
      logic [4:0] linreg_b_voltage_code;
      logic [7:0] stepdown_a_sequence_delay;
      logic [7:0] stepdown_b_sequence_delay;
      logic [7:0] linreg_a_sequence_delay;
      logic [TICK_W-1:0] tick_count;
      logic [7:0] rdata;
   } resq_state_t;

   resq_state_t st;
   resq_state_t next_st;
   logic pin_rise;
   logic pin_fall;
   logic tick;

   // ***************************************************
   // Pin edges and time base
   // ***************************************************
   // Edge only once second and third stage agree
   assign pin_rise = (st.pin_sync[2:1] == 2'b11) && !st.pin_level;
   assign pin_fall = (st.pin_sync[2:1] == 2'b00) && st.pin_level;
   assign tick = (st.tick_count == TICK_W'(STEP_CYCLES - 1)); // RULE13

   // ***************************************************
   // Register file and next state
   // ***************************************************
   always_comb
   begin
      next_st = st;
      next_st.pin_sync = {st.pin_sync[1:0], enable_pin};
      if (pin_rise)
         next_st.pin_level = 1'b1;
      else if (pin_fall)
         next_st.pin_level = 1'b0;
      // Free-running tick; restart on edge gives full first step
      if (tick || pin_rise || pin_fall)
         next_st.tick_count = '0; // RULE13
      else
         next_st.tick_count = st.tick_count + TICK_W'(1);
      if (reg_write)
      begin
         case (reg_addr)
            resq_pkg::LINREG_B_CONTROL_ADDR:
            begin
               next_st.linreg_b_discharge_on =
                  reg_wdata[resq_pkg::DISCHARGE_BIT];
               next_st.linreg_b_pin_gating =
                  reg_wdata[resq_pkg::PIN_GATING_BIT];
               next_st.linreg_b_sw_on =
                  reg_wdata[resq_pkg::SW_ON_BIT]; // RULE3
            end
            resq_pkg::LINREG_A_VOLTAGE_ADDR:
               next_st.linreg_a_voltage_code =
                  reg_wdata[resq_pkg::CODE_W-1:0]; // RULE4
            resq_pkg::LINREG_B_VOLTAGE_ADDR:
               next_st.linreg_b_voltage_code =
                  reg_wdata[resq_pkg::CODE_W-1:0]; // RULE5
            resq_pkg::STEPDOWN_A_SEQUENCE_DELAY_ADDR:
               next_st.stepdown_a_sequence_delay = reg_wdata;
            resq_pkg::STEPDOWN_B_SEQUENCE_DELAY_ADDR:
               next_st.stepdown_b_sequence_delay = reg_wdata;
            resq_pkg::LINREG_A_SEQUENCE_DELAY_ADDR:
               next_st.linreg_a_sequence_delay = reg_wdata;
            default:
               next_st.rdata = st.rdata;
         endcase
      end
      // Read data registered; reserved bits read zero
      case (reg_addr)
         resq_pkg::LINREG_B_CONTROL_ADDR:
            next_st.rdata = {5'h00, next_st.linreg_b_discharge_on,
                             next_st.linreg_b_pin_gating,
                             next_st.linreg_b_sw_on};
         resq_pkg::LINREG_A_VOLTAGE_ADDR:
            next_st.rdata = {3'h0, next_st.linreg_a_voltage_code};
         resq_pkg::LINREG_B_VOLTAGE_ADDR:
            next_st.rdata = {3'h0, next_st.linreg_b_voltage_code};
         resq_pkg::STEPDOWN_A_SEQUENCE_DELAY_ADDR:
            next_st.rdata = next_st.stepdown_a_sequence_delay;
         resq_pkg::STEPDOWN_B_SEQUENCE_DELAY_ADDR:
            next_st.rdata = next_st.stepdown_b_sequence_delay;
         resq_pkg::LINREG_A_SEQUENCE_DELAY_ADDR:
            next_st.rdata = next_st.linreg_a_sequence_delay;
         default:
            next_st.rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         st <= '0;
         st.linreg_b_discharge_on <=
            resq_pkg::LINREG_B_CONTROL_RST[resq_pkg::DISCHARGE_BIT]; // RULE1
         st.linreg_a_voltage_code <= resq_pkg::VOLTAGE_CODE_RST;
         st.linreg_b_voltage_code <= resq_pkg::VOLTAGE_CODE_RST;
         st.stepdown_a_sequence_delay <= resq_pkg::SEQUENCE_DELAY_RST;
         st.stepdown_b_sequence_delay <= resq_pkg::SEQUENCE_DELAY_RST;
         st.linreg_a_sequence_delay <= resq_pkg::SEQUENCE_DELAY_RST;
      end
      else if (clk_en)
         st <= next_st;
   end

   // ***************************************************
   // Regulator B enable and discharge
   // ***************************************************
   assign linreg_b_on = st.linreg_b_sw_on &&
      (!st.linreg_b_pin_gating || st.pin_level); // RULE2 RULE3
   assign linreg_b_discharge = !linreg_b_on &&
      st.linreg_b_discharge_on; // RULE1
   assign reg_rdata = st.rdata;
   assign reg_addr_error = reg_write &&
      (reg_addr < resq_pkg::LINREG_B_CONTROL_ADDR ||
       reg_addr > resq_pkg::LINREG_A_SEQUENCE_DELAY_ADDR);
   assign linreg_a_voltage_code = st.linreg_a_voltage_code;
   assign linreg_b_voltage_code = st.linreg_b_voltage_code;
   // Reserved codes flagged, not clipped, so software sees its write
   assign linreg_a_code_reserved =
      st.linreg_a_voltage_code > resq_pkg::VOLTAGE_CODE_MAX; // RULE4
   assign linreg_b_code_reserved =
      st.linreg_b_voltage_code > resq_pkg::VOLTAGE_CODE_MAX; // RULE5

   // ***************************************************
   // Sequenced outputs
   // ***************************************************
   resq_delay_channel #(.TICK_W(TICK_W)) u_stepdown_a (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .pin_rise(pin_rise),
      .pin_fall(pin_fall),
      .tick(tick),
      .on_wait(st.stepdown_a_sequence_delay[resq_pkg::ON_WAIT_LSB +: 4]),
      .off_wait(st.stepdown_a_sequence_delay[resq_pkg::OFF_WAIT_LSB +: 4]),
      .on_double(on_step_double),
      .off_double(off_step_double),
      .active(stepdown_a_on)
   ); // RULE6 RULE7

   resq_delay_channel #(.TICK_W(TICK_W)) u_stepdown_b (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .pin_rise(pin_rise),
      .pin_fall(pin_fall),
      .tick(tick),
      .on_wait(st.stepdown_b_sequence_delay[resq_pkg::ON_WAIT_LSB +: 4]),
      .off_wait(st.stepdown_b_sequence_delay[resq_pkg::OFF_WAIT_LSB +: 4]),
      .on_double(on_step_double),
      .off_double(off_step_double),
      .active(stepdown_b_on)
   ); // RULE8 RULE9

   resq_delay_channel #(.TICK_W(TICK_W)) u_linreg_a (
      .ref_clk(ref_clk),
      .reset(reset),
      .clk_en(clk_en),
      .pin_rise(pin_rise),
      .pin_fall(pin_fall),
      .tick(tick),
      .on_wait(st.linreg_a_sequence_delay[resq_pkg::ON_WAIT_LSB +: 4]),
      .off_wait(st.linreg_a_sequence_delay[resq_pkg::OFF_WAIT_LSB +: 4]),
      .on_double(on_step_double),
      .off_double(off_step_double),
      .active(linreg_a_on)
   ); // RULE10 RULE11
endmodule

/* dv/resq_sequencer_sva.sv */
// ********
// Port checks
// ********
module resq_sequencer_sva (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic reg_write,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_addr_error,
   input wire logic enable_pin,
   input wire logic linreg_b_on,
   input wire logic linreg_b_discharge,
   input wire logic [4:0] linreg_a_voltage_code,
   input wire logic stepdown_a_on,
   input wire logic stepdown_b_on,
   input wire logic linreg_a_on
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   // Frozen cycles take no write, so checks rest with the enable
   default disable iff (reset || !clk_en);
   // Writes to the control byte and the regulator A code
   wire logic w09 = reg_write && reg_addr == 8'h09;
   wire logic wa = reg_write && reg_addr == 8'h0a;
   property p_disch; linreg_b_discharge |-> !linreg_b_on; endproperty
   a_disch: assert property (p_disch) else $error("discharge on");
   property p_off; w09 && !reg_wdata[0] |=> !linreg_b_on
      && linreg_b_discharge == $past(reg_wdata[2]); endproperty
   a_off: assert property (p_off) else $error("sw off ignored");
   property p_on; w09 && reg_wdata[1:0] == 2'b01 |=> linreg_b_on; endproperty
   a_on: assert property (p_on) else $error("sw on ignored");
   property p_ca; wa |=> linreg_a_voltage_code == $past(reg_wdata[4:0]);
   endproperty
   a_ca: assert property (p_ca) else $error("code a wrong");
   property p_rd; reg_write && reg_addr inside {[8'h0c:8'h0e]}
      |=> reg_rdata == $past(reg_wdata); endproperty
   a_rd: assert property (p_rd) else $error("delay readback");
   // Refused writes flag at once and read back as zero
   property p_bad; reg_write && !(reg_addr inside {[8'h09:8'h0e]})
      |-> reg_addr_error ##1 reg_rdata == 8'h00; endproperty
   a_bad: assert property (p_bad) else $error("unmapped write");
   // An output may only follow a pin level that it has seen
   property p_up; $rose(stepdown_a_on) || $rose(stepdown_b_on)
      || $rose(linreg_a_on) |-> $past(enable_pin, 3); endproperty
   a_up: assert property (p_up) else $error("early start");
   property p_dn; $fell(stepdown_a_on) || $fell(stepdown_b_on)
      || $fell(linreg_a_on) |-> !$past(enable_pin, 3); endproperty
   a_dn: assert property (p_dn) else $error("early stop");
   // Fastest start is four edges behind the pin: sync plus one register
   property p_dl; $rose(linreg_a_on) |-> $past(enable_pin, 4); endproperty
   a_dl: assert property (p_dl) else $error("ldo a stray");
endmodule

/* dv/resq_host_model.sv */
// ********
// Register host
// ********
module resq_host_model (
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_write,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      reg_write = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // One write strobe; data scrambled after so stale bytes never match
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      reg_wdata <= ~d;
   endtask
   // Read data is registered, so wait two edges past the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      repeat (2) @(posedge ref_clk);
      d = reg_rdata;
   endtask
endmodule

/* dv/resq_sequencer_test.sv */
module resq_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ********
   // Bench
   // ********
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic pin = 1'b0;
   logic on_dbl = 1'b0;
   logic off_dbl = 1'b0;
   logic ce = 1'b1;
   logic wr, err, b_on, b_dis, res_a, res_b, sd_a, sd_b, la;
   logic [7:0] addr, wdata, rdata, d, q;
   logic [4:0] code_a, code_b;
   logic [3:0] on_c [3];
   logic [3:0] off_c [3];
   int n_mismatch = 0;
   int num_checks = 0;
   int seed = 8;
   int i;
   always #10 ref_clk = ~ref_clk;
   resq_host_model host (.ref_clk(ref_clk), .reg_rdata(rdata),
      .reg_write(wr), .reg_addr(addr), .reg_wdata(wdata));
   resq_sequencer #(.STEP_CYCLES(4)) u_dut (.ref_clk(ref_clk),
      .reset(reset), .clk_en(ce), .enable_pin(pin),
      .on_step_double(on_dbl), .off_step_double(off_dbl),
      .reg_write(wr), .reg_addr(addr), .reg_wdata(wdata),
      .reg_rdata(rdata), .reg_addr_error(err), .linreg_b_on(b_on),
      .linreg_b_discharge(b_dis), .linreg_a_voltage_code(code_a),
      .linreg_b_voltage_code(code_b), .linreg_a_code_reserved(res_a),
      .linreg_b_code_reserved(res_b), .stepdown_a_on(sd_a),
      .stepdown_b_on(sd_b), .linreg_a_on(la));
   // Cycles from pin move to output: sync, steps, one register
   function automatic logic [15:0] exp_wait(logic [3:0] c, logic dbl);
      return 16'h4 + 16'(c) * (dbl ? 16'h8 : 16'h4);
   endfunction
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Time all three outputs; each must land on its expected cycle exactly
   task automatic move(logic lvl, logic dbl, logic [3:0] c [3]);
      logic [15:0] at [3];
      logic [2:0] hit;
      logic [2:0] o;
      hit = 3'h0;
      @(posedge ref_clk);
      pin <= lvl;
      for (int n = 0; n < 300 && hit != 3'h7; n++)
      begin
         @(posedge ref_clk);
         o = {la, sd_b, sd_a};
         for (int k = 0; k < 3; k++)
            if (!hit[k] && o[k] === lvl)
            begin
               hit[k] = 1'b1;
               at[k] = 16'(n);
            end
      end
      // Timing is exact: the step counter restarts on the pin edge
      check("wait a", at[0], exp_wait(c[0], dbl));
      check("wait b", at[1], exp_wait(c[1], dbl));
      check("wait l", at[2], exp_wait(c[2], dbl));
   endtask
   // Main sequence: reset, control, codes, refusals, delays
   initial
   begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      check("discharge", 16'(b_dis), 16'h1);
      for (i = 9; i < 15; i++)
      begin
         host.rd(8'(i), d);
         check("reset value", 16'(d), (i == 9) ? 16'h4 : 16'h0);
      end
      for (i = 0; i < 16; i++)
      begin
         pin <= i[3];
         host.wr(8'h09, 8'(i[2:0]));
         repeat (5) @(posedge ref_clk);
         d[0] = i[0] && (!i[1] || i[3]);
         check("b on", 16'(b_on), 16'(d[0]));
         check("b discharge", 16'(b_dis), 16'(!d[0] && i[2]));
      end
      for (i = 0; i < 8; i++)
      begin
         d = (i == 0) ? 8'h19 : (i == 1) ? 8'h3a : 8'($random(seed));
         host.wr(8'h0a, d);
         check("error", 16'(err), 16'h0);
         host.wr(8'h0b, ~d);
         host.rd(8'h0b, q);
         check("code b", 16'(code_b), {11'h0, ~d[4:0]});
         check("code a", 16'(code_a), 16'(d[4:0]));
         check("res a", 16'(res_a), 16'(d[4:0] > 5'h19));
         check("res b", 16'(res_b), 16'(~d[4:0] > 5'h19));
         check("read b", 16'(q), {11'h0, ~d[4:0]});
      end
      // Clock enable low: a write must not land
      ce <= 1'b0;
      host.wr(8'h0a, ~d);
      ce <= 1'b1;
      @(posedge ref_clk);
      check("freeze", 16'(code_a), 16'(d[4:0]));
      for (i = 0; i < 4; i++)
      begin
         d = (i == 0) ? 8'h08 : (i == 1) ? 8'h0f : 8'h10 | 8'($random(seed));
         host.wr(d, 8'hff);
         check("error", 16'(err), 16'h1);
         host.rd(d, q);
         check("unmapped", 16'(q), 16'h0);
      end
      // Pin left high by the control loop; settle it low first
      pin <= 1'b0;
      repeat (8) @(posedge ref_clk);
      for (i = 0; i < 5; i++)
      begin
         for (int k = 0; k < 3; k++)
         begin
            on_c[k] = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'($random(seed));
            off_c[k] = (i == 0) ? 4'h1 : (i == 1) ? 4'hf : 4'($random(seed));
            host.wr(8'h0c + 8'(k), {off_c[k], on_c[k]});
         end
         on_dbl <= i[0];
         off_dbl <= i[1];
         move(1'b1, i[0], on_c);
         move(1'b0, i[1], off_c);
      end
      conclude();
   end
   // Watchdog at 20000 cycles, far beyond the fewer than 2000 cycles needed
   initial
   begin
      #400000;
      n_mismatch++;
      conclude();
   end
endmodule
bind resq_sequencer resq_sequencer_sva u_sva (.ref_clk(ref_clk),
   .reset(reset), .clk_en(clk_en), .reg_write(reg_write),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_addr_error(reg_addr_error), .enable_pin(enable_pin),
   .linreg_b_on(linreg_b_on), .linreg_b_discharge(linreg_b_discharge),
   .linreg_a_voltage_code(linreg_a_voltage_code),
   .stepdown_a_on(stepdown_a_on), .stepdown_b_on(stepdown_b_on),
   .linreg_a_on(linreg_a_on));
